//--- pkg/egw_pkg.sv
// Package for the enable-gated watchdog timer: timing, register map and state types
package egw_pkg;

    localparam int unsigned CLOCK_HZ     = 200_000_000;
    localparam int unsigned CLOCK_NS     = 5;

    // Timing figures in their own units
    localparam int unsigned T_RST_MS     = 200;
    localparam int unsigned T_WD_LONG_MS = 1600;
    localparam int unsigned T_WD_SHORT_MS = 200;
    localparam int unsigned T_EN_OUT_NS  = 200;

    // Derived cycle counts
    localparam longint unsigned CYC_PER_MS = longint'(CLOCK_HZ) / 64'd1000;
    localparam longint unsigned RST_CYC_D  = longint'(T_RST_MS) * CYC_PER_MS;
    localparam longint unsigned WDL_CYC_D  = longint'(T_WD_LONG_MS) * CYC_PER_MS;
    localparam longint unsigned WDS_CYC_D  = longint'(T_WD_SHORT_MS) * CYC_PER_MS;
    localparam int unsigned     EN_OUT_CYC = (T_EN_OUT_NS + CLOCK_NS - 1) / CLOCK_NS;

    localparam int unsigned CNT_W = 32;

    // Register map
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ    = 4'h8;
    localparam logic [3:0] ADDR_MASK   = 4'hc;

    // Control fields
    localparam int unsigned CTRL_SEL_BIT = 0;
    localparam int unsigned CTRL_CAP_BIT = 1;
    localparam int unsigned CTRL_EN_BIT  = 2;
    localparam logic [2:0]  CTRL_RESET   = 3'h5;

    // Interrupt bits
    localparam int unsigned IRQ_W       = 2;
    localparam int unsigned IRQ_TIMEOUT = 0;
    localparam int unsigned IRQ_RELEASE = 1;

    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_DELAY = 4'h2,
        ST_WATCH = 4'h4,
        ST_RESET = 4'h8
    } egw_state_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } egw_bus_type;

endpackage

//--- hdl/egw_top.sv
// Enable-gated watchdog timer with register port and interrupt
`timescale 1ns/1ps
module egw_top
    import egw_pkg::*;
#(
    parameter logic [CNT_W-1:0] RST_CYC = CNT_W'(RST_CYC_D),
    parameter logic [CNT_W-1:0] WDL_CYC = CNT_W'(WDL_CYC_D),
    parameter logic [CNT_W-1:0] WDS_CYC = CNT_W'(WDS_CYC_D)
) (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_kick_input,
    input  wire logic        i_enable,
    input  wire logic        i_timeout_select_input,
    input  wire logic        i_timing_capacitor_pin,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_irq,
    output logic             o_timeout_reset_output,
    output logic             o_timeout_reset_output_oe,
    output logic             o_enable_follow_output,
    output logic             o_enable_follow_output_oe
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0]       kick_sync;
        logic [2:0]       en_sync;
        logic [2:0]       sel_sync;
        logic [2:0]       cap_sync;
        logic             kick_st;
        logic             en_st;
        logic             sel_st;
        logic             cap_st;
        egw_state_type    state;
        logic [CNT_W-1:0] cnt;
        logic [7:0]       en_low_cnt;
        logic             follow_low;
        logic [2:0]       ctrl;
        logic [IRQ_W-1:0] irq;
        logic [IRQ_W-1:0] mask;
        logic [31:0]      rdata;
    } egw_regs_type;

    egw_regs_type regs_r;
    egw_regs_type regs_nxt;
    egw_bus_type  bus;

    logic             en_eff;
    logic             sel_eff;
    logic             cap_eff;
    logic             kick_fall;
    logic [CNT_W-1:0] timeout_cyc;
    logic [IRQ_W-1:0] irq_set;

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Software may override the enable and select pins by clearing their control bits, the capacitor pin by setting its bit
    assign en_eff  = regs_r.en_st & regs_r.ctrl[CTRL_EN_BIT];
    assign sel_eff = regs_r.sel_st & regs_r.ctrl[CTRL_SEL_BIT];
    assign cap_eff = regs_r.cap_st | regs_r.ctrl[CTRL_CAP_BIT];
    // Capacitor pin high means pulled up; low means open
    assign timeout_cyc = cap_eff ? WDS_CYC : WDL_CYC;

    // ==========================================================
    // Next state
    always_comb begin
        regs_nxt = regs_r;
        irq_set  = '0;
        kick_fall = 1'b0;

        regs_nxt.kick_sync = {regs_r.kick_sync[1:0], i_kick_input};
        regs_nxt.en_sync   = {regs_r.en_sync[1:0], i_enable};
        regs_nxt.sel_sync  = {regs_r.sel_sync[1:0], i_timeout_select_input};
        regs_nxt.cap_sync  = {regs_r.cap_sync[1:0], i_timing_capacitor_pin};
        // A change counts once the second and third stages agree
        if (regs_r.kick_sync[1] == regs_r.kick_sync[2]) begin
            regs_nxt.kick_st = regs_r.kick_sync[2];
            kick_fall = regs_r.kick_st & ~regs_r.kick_sync[2];
        end
        if (regs_r.en_sync[1] == regs_r.en_sync[2]) begin
            regs_nxt.en_st = regs_r.en_sync[2];
        end
        if (regs_r.sel_sync[1] == regs_r.sel_sync[2]) begin
            regs_nxt.sel_st = regs_r.sel_sync[2];
        end
        if (regs_r.cap_sync[1] == regs_r.cap_sync[2]) begin
            regs_nxt.cap_st = regs_r.cap_sync[2];
        end

        // Enable-follow pull-down after the propagation delay
        if (en_eff) begin
            regs_nxt.en_low_cnt = '0;
        end else if (regs_r.en_low_cnt < 8'(EN_OUT_CYC - 1)) begin
            regs_nxt.en_low_cnt = regs_r.en_low_cnt + 8'h01;
        end else begin
            regs_nxt.follow_low = 1'b1;
        end

        case (regs_r.state)
            ST_OFF: begin
                if (en_eff) begin
                    regs_nxt.state = ST_DELAY;
                    regs_nxt.cnt   = '0;
                end
            end
            ST_DELAY: begin
                if (regs_r.cnt >= RST_CYC - 1) begin
                    regs_nxt.state      = ST_WATCH;
                    regs_nxt.cnt        = '0;
                    regs_nxt.follow_low = 1'b0;
                    irq_set[IRQ_RELEASE] = 1'b1;
                end else begin
                    regs_nxt.cnt = regs_r.cnt + 1'b1;
                end
            end
            ST_WATCH: begin
                if (!sel_eff) begin
                    regs_nxt.cnt = '0;
                end else if (kick_fall) begin
                    regs_nxt.cnt = '0;
                end else if (regs_r.cnt >= timeout_cyc - 1) begin
                    regs_nxt.state = ST_RESET;
                    regs_nxt.cnt   = '0;
                    irq_set[IRQ_TIMEOUT] = 1'b1;
                end else begin
                    regs_nxt.cnt = regs_r.cnt + 1'b1;
                end
            end
            ST_RESET: begin
                // Kicks are not looked at here
                if (regs_r.cnt >= RST_CYC - 1) begin
                    regs_nxt.state = ST_WATCH;
                    regs_nxt.cnt   = '0;
                end else begin
                    regs_nxt.cnt = regs_r.cnt + 1'b1;
                end
            end
            default: begin
                regs_nxt.state = ST_OFF;
                regs_nxt.cnt   = '0;
            end
        endcase

        // Enable low wins over the next state and count: single reset cycle or permanent off
        if (!en_eff) begin
            regs_nxt.state = ST_OFF;
            regs_nxt.cnt   = '0;
        end

        // Register port
        regs_nxt.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL:   regs_nxt.rdata = {29'h0, regs_r.ctrl};
                ADDR_STATUS: regs_nxt.rdata = {24'h0, regs_r.follow_low, en_eff, sel_eff,
                                               cap_eff, regs_r.state};
                ADDR_IRQ:    regs_nxt.rdata = {30'h0, regs_r.irq};
                ADDR_MASK:   regs_nxt.rdata = {30'h0, regs_r.mask};
                default:     regs_nxt.rdata = '0;
            endcase
        end
        if (bus.wr && bus.addr == ADDR_CTRL) begin
            regs_nxt.ctrl = bus.wdata[2:0];
        end
        if (bus.wr && bus.addr == ADDR_MASK) begin
            regs_nxt.mask = bus.wdata[IRQ_W-1:0];
        end
        // Set beats a same-cycle write-one clear
        if (bus.wr && bus.addr == ADDR_IRQ) begin
            regs_nxt.irq = (regs_r.irq & ~bus.wdata[IRQ_W-1:0]) | irq_set;
        end else begin
            regs_nxt.irq = regs_r.irq | irq_set;
        end

        if (!i_resetn) begin
            regs_nxt = '0;
            // Kick stages start at the idle level so leaving reset shows no false edge
            regs_nxt.kick_sync  = 3'h7;
            regs_nxt.kick_st    = 1'b1;
            regs_nxt.state      = ST_OFF;
            regs_nxt.follow_low = 1'b1;
            regs_nxt.ctrl       = CTRL_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        regs_r <= regs_nxt;
    end

    // ==========================================================
    // Outputs: open-drain pins only ever drive low
    assign o_timeout_reset_output    = 1'b0;
    assign o_timeout_reset_output_oe = (regs_r.state == ST_RESET);
    assign o_enable_follow_output    = 1'b0;
    assign o_enable_follow_output_oe = regs_r.follow_low;
    assign o_rdata = regs_r.rdata;
    assign o_irq   = |(regs_r.irq & regs_r.mask);

    // ==========================================================
    // Checks
    sequence s_reset_entry;
        $rose(o_timeout_reset_output_oe);
    endsequence

    property p_reset_hold;
        @(posedge i_clock) disable iff (!i_resetn)
        s_reset_entry |-> o_timeout_reset_output_oe [*8];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset pulse too short");

    property p_off_no_reset;
        @(posedge i_clock) disable iff (!i_resetn)
        !en_eff |=> !o_timeout_reset_output_oe;
    endproperty
    a_off_no_reset: assert property (p_off_no_reset) else $error("reset low while off");

    property p_sel_off;
        @(posedge i_clock) disable iff (!i_resetn)
        (regs_r.state == ST_WATCH && !sel_eff) |=> regs_r.state != ST_RESET;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("timeout while disabled");

    property p_kick_restart;
        @(posedge i_clock) disable iff (!i_resetn)
        (regs_r.state == ST_WATCH && en_eff && kick_fall) |=> regs_r.cnt == '0;
    endproperty
    a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart");

    property p_follow_low;
        @(posedge i_clock) disable iff (!i_resetn)
        $fell(en_eff) |-> ##[1:45] o_enable_follow_output_oe;
    endproperty
    a_follow_low: assert property (p_follow_low) else $error("follow not pulled low");

    property p_follow_release;
        @(posedge i_clock) disable iff (!i_resetn)
        $fell(o_enable_follow_output_oe) |-> $past(regs_r.state) == ST_DELAY;
    endproperty
    a_follow_release: assert property (p_follow_release) else $error("early release");

    property p_timeout_sel;
        @(posedge i_clock) disable iff (!i_resetn)
        (regs_r.state == ST_WATCH) ##1 (regs_r.state == ST_RESET)
            |-> $past(regs_r.cnt) == $past(timeout_cyc) - 1;
    endproperty
    a_timeout_sel: assert property (p_timeout_sel) else $error("wrong timeout");

    property p_reset_ignores_kick;
        @(posedge i_clock) disable iff (!i_resetn)
        (regs_r.state == ST_RESET && en_eff && regs_r.cnt < RST_CYC - 1)
            |=> regs_r.cnt == $past(regs_r.cnt) + 1;
    endproperty
    a_reset_ignores_kick: assert property (p_reset_ignores_kick) else $error("kick seen");

    // A natural release ends a full pulse; any release restarts the count
    sequence s_reset_exit;
        $fell(o_timeout_reset_output_oe) && $past(en_eff);
    endsequence

    property p_reset_length;
        @(posedge i_clock) disable iff (!i_resetn)
        s_reset_exit |-> $past(regs_r.cnt) == RST_CYC - 1;
    endproperty
    a_reset_length: assert property (p_reset_length) else $error("pulse length");

    property p_rel_restart;
        @(posedge i_clock) disable iff (!i_resetn)
        $fell(o_timeout_reset_output_oe) |-> regs_r.cnt == '0;
    endproperty
    a_rel_restart: assert property (p_rel_restart) else $error("no restart");

    // The timeout flag must be up on the edge that enters the pulse, whatever the clear does
    sequence s_timeout_step;
        (regs_r.state == ST_WATCH) ##1 (regs_r.state == ST_RESET);
    endsequence

    property p_timeout_irq;
        @(posedge i_clock) disable iff (!i_resetn)
        s_timeout_step |-> regs_r.irq[IRQ_TIMEOUT];
    endproperty
    a_timeout_irq: assert property (p_timeout_irq) else $error("no timeout flag");

endmodule

//--- verification/egw_kicker.sv
// Host-side model that kicks the watchdog at a programmable interval
`timescale 1ns/1ps
module egw_kicker (
    input  wire logic       i_clock,
    input  wire logic       i_run,
    input  wire logic [7:0] i_period,
    output logic            o_kick
);
    // ==========================================
    // Kick generator
    logic [7:0] cnt_r;
    always_ff @(posedge i_clock) begin
        cnt_r <= (!i_run || cnt_r >= i_period) ? 8'h00 : cnt_r + 8'h01;
    end
    // Never floats: idle high, one falling edge per interval
    assign o_kick = !(i_run && cnt_r < 8'h04);
endmodule

//--- verification/tb_top.sv
// Self-checking testbench for the enable-gated watchdog timer
`timescale 1ns/1ps
module tb_top;
    import egw_pkg::*;
    // ==========================================
    // Setup
    localparam int RST = 100;
    localparam int WDL = 400;
    localparam int WDS = 50;
    logic        i_clock, i_resetn, i_enable, i_sel, i_cap, i_wr, i_rd, run, kick;
    logic [3:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic        o_irq, rst_o, rst_oe, fol_o, fol_oe;
    int          err_count, checks, n;

    egw_top #(.RST_CYC(32'(RST)), .WDL_CYC(32'(WDL)), .WDS_CYC(32'(WDS))) egw_top_inst (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_kick_input(kick), .i_enable(i_enable),
        .i_timeout_select_input(i_sel), .i_timing_capacitor_pin(i_cap), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_timeout_reset_output(rst_o), .o_timeout_reset_output_oe(rst_oe),
        .o_enable_follow_output(fol_o), .o_enable_follow_output_oe(fol_oe));
    egw_kicker egw_kicker_inst (.i_clock(i_clock), .i_run(run), .i_period(8'h14),
        .o_kick(kick));

    always #2.5 i_clock = ~i_clock;

    // ==========================================
    // Helpers
    task summarize;
        $display("Checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task rng(input string name, input int v, input int lo, input int hi);
        chk(name, 32'(v >= lo && v <= hi), 32'h1);
    endtask
    // Counts edges until the chosen oe (0 reset, 1 follow) shows v; a forced bound fails
    task wt(input int s, input logic v, input int bnd, input bit must, output int c);
        c = 0;
        #1;
        while ((s == 0 ? rst_oe : fol_oe) !== v && c < bnd) begin
            @(posedge i_clock);
            #1;
            c++;
        end
        if (must && c >= bnd) begin
            chk("wait_bound", 32'h0, 32'h1);
            summarize();
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clock);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    // ==========================================
    // Scenarios
    task t_reset;
        chk("rst_oe", rst_oe, 32'h0);
        chk("fol_oe", fol_oe, 32'h1);
        chk("pins", {rst_o, fol_o}, 32'h0);
        rd(ADDR_CTRL, d); chk("ctrl", d, 32'h5);
        rd(4'h2, d); chk("unmapped", d, 32'h0);
        wr(ADDR_MASK, 32'h3);
        $display("t_reset done");
    endtask
    task t_enable;
        @(posedge i_clock) i_enable <= 1'b1;
        wt(1, 1'b0, RST + 20, 1, n); rng("follow_delay", n, RST, RST + 8);
        chk("rst_oe", rst_oe, 32'h0);
        rd(ADDR_IRQ, d); chk("irq_release", d, 32'h2);
        chk("irq_pin", o_irq, 32'h1);
        wr(ADDR_IRQ, 32'h2); #1 chk("irq_clear", o_irq, 32'h0);
        rd(ADDR_STATUS, d); chk("status", d, 32'h74);
        $display("t_enable done");
    endtask
    task t_timeouts;
        wt(0, 1'b1, WDS + 20, 1, n);
        wt(0, 1'b0, RST + 10, 1, n); chk("pulse_len", 32'(n), 32'(RST));
        wt(0, 1'b1, WDS + 10, 1, n); rng("short_to", n, WDS - 1, WDS + 2);
        rd(ADDR_IRQ, d); chk("irq_timeout", d, 32'h1);
        chk("irq_pin", o_irq, 32'h1);
        wr(ADDR_MASK, 32'h2); #1 chk("irq_masked", o_irq, 32'h0);
        wr(ADDR_IRQ, 32'h1);
        wr(ADDR_MASK, 32'h3);
        wt(0, 1'b0, RST, 1, n);
        @(posedge i_clock) i_cap <= 1'b0;
        wt(0, 1'b1, WDL + 10, 1, n); rng("long_to", n + 1, WDL - 1, WDL + 2);
        $display("t_timeouts done");
    endtask
    task t_kick;
        @(posedge i_clock);
        i_cap <= 1'b1; run <= 1'b1;
        wt(0, 1'b0, RST + 10, 1, n); chk("kick_in_rst", 32'(n + 1), 32'(RST));
        wt(0, 1'b1, 300, 0, n); chk("kicked", 32'(n), 32'd300);
        $display("t_kick done");
    endtask
    task t_disabled;
        @(posedge i_clock);
        i_sel <= 1'b0; run <= 1'b0;
        wt(0, 1'b1, 600, 0, n); chk("sel_off", 32'(n), 32'd600);
        $display("t_disabled done");
    endtask
    task t_enable_low;
        @(posedge i_clock) i_sel <= 1'b1;
        wt(0, 1'b1, WDS + 20, 1, n);
        @(posedge i_clock) i_enable <= 1'b0;
        wt(1, 1'b1, 60, 1, n); rng("follow_low", n, 1, 45);
        @(posedge i_clock);
        #1 chk("rst_release", rst_oe, 32'h0);
        @(posedge i_clock) i_enable <= 1'b1;
        wt(1, 1'b0, RST + 20, 1, n); rng("one_cycle", n, RST, RST + 8);
        chk("rst_after", rst_oe, 32'h0);
        $display("t_enable_low done");
    endtask

    // ==========================================
    // Main sequence
    initial begin
        i_clock = 1'b0; i_resetn = 1'b0; i_enable = 1'b0; i_sel = 1'b1; i_cap = 1'b1;
        i_wr = 1'b0; i_rd = 1'b0; run = 1'b0; i_addr = 4'h0; i_wdata = 32'h0;
        err_count = 0; checks = 0;
        repeat (3) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        #1;
        t_reset();
        t_enable();
        t_timeouts();
        t_kick();
        t_disabled();
        t_enable_low();
        summarize();
    end
endmodule
